// *** spfc_codec_model.sv ***
// external codec: drives bit clock, frame sync and receive data, reads txd
`timescale 1ns/1ps
module spfc_codec_model
#(
  parameter int HALF = 6
)
(
  // clock
  input wire logic clock_i,
  // from the port
  input wire logic txd_i,
  input wire logic txd_oe_n_i,
  // to the port
  output logic sck_o,
  output logic fs_o,
  output logic rxd_o,
  // observations
  output logic [7:0] tx_seen_o,
  output int oe_miss_o
);
  initial
  begin
    sck_o = 1'b0;
    fs_o = 1'b0;
    rxd_o = 1'b0;
    tx_seen_o = 8'h00;
    oe_miss_o = 0;
  end

  // one bit slot: sync and data change on the rise, txd read before the fall
  task automatic slot(input logic fsv, input logic dv, input int idx);
    @(posedge clock_i);
    sck_o <= 1'b1;
    fs_o <= fsv;
    rxd_o <= dv;
    repeat (HALF - 1) @(posedge clock_i);
    if (idx >= 0)
    begin
      tx_seen_o[idx] = txd_i;
      if (txd_oe_n_i !== 1'b0) oe_miss_o++;
    end
    @(posedge clock_i);
    sck_o <= 1'b0;
    repeat (HALF - 1) @(posedge clock_i);
  endtask

  // one 8-bit frame; mode 0 word sync, 1 bit sync, 2 gated with no sync
  task automatic frame(input logic [7:0] w, input int mode, input bit lsb,
                       input bit early);
    int i;
    int b;
    tx_seen_o = 8'h00;
    if (mode == 1) slot(1'b1, ~rxd_o, -1);
    for (i = 0; i < 8; i++)
    begin
      b = lsb ? i : 7 - i;
      slot((mode == 0) || (early && i == 3), w[b], b);
    end
    // a continuous clock runs on with the sync low, so the next leading
    // edge is seen; a gated clock must stay still between words
    if (mode != 2) slot(1'b0, ~w[lsb ? 7 : 0], -1);
    // clock stands still; no fresh sync until the word is done
    @(posedge clock_i);
    fs_o <= 1'b0;
    rxd_o <= ~w[lsb ? 7 : 0]; // released line shows the inverse level
  endtask
endmodule

// *** spfc_pkg.sv ***
// constants, register layouts and carrier types for the serial port framing block
// Operation
// - sync select clear: independent tx and rx timing
// - sync select set: one shared clock, frame sync
// - separate receive and transmit interrupt requests
// - internal bit clock from prescalers, frame dividers
// - gated sync: clock pin, flags, pin two sync
// - gated async: pin zero rx clock, syncs
// - continuous sync: pin two shared frame sync
// - continuous async: pin one rx, two tx sync
// - length select clear: word-long frame sync
// - length select set: one-bit sync before data
// - length mix gives rx and tx opposite lengths
// - rx ignores frame sync edge before frame ends
// - transmit data high impedance between frames
// - shift direction clear: msb first both ways
// - shift direction set: lsb first both ways
// - external gated: enable rise first, disable fall last
// - external gated clock ignores frame sync entirely
package spfc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] SPFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPFC_OFF_DIV = 8'h04;
  localparam logic [7:0] SPFC_OFF_TXD = 8'h08;
  localparam logic [7:0] SPFC_OFF_RXD = 8'h0c;
  localparam logic [7:0] SPFC_OFF_STAT = 8'h10;
  localparam logic [7:0] SPFC_OFF_MASK = 8'h14;

  // sticky event bit positions in status and mask
  localparam int SPFC_ST_TXE = 0;
  localparam int SPFC_ST_TXU = 1;
  localparam int SPFC_ST_RXF = 2;
  localparam int SPFC_ST_RXO = 3;
  localparam int SPFC_ST_DROP = 4;
  localparam int SPFC_ST_W = 5;

  // reset values
  localparam logic [31:0] SPFC_CTRL_RST = 32'h000f_0000;
  localparam logic [31:0] SPFC_DIV_RST = 32'h0000_0000;
  localparam logic [4:0] SPFC_MASK_RST = 5'h00;

  // half bit period multiplier: 2 * (fixed prescale 1 or 8)
  localparam logic [16:0] SPFC_HALF_MUL1 = 17'h00002;
  localparam logic [16:0] SPFC_HALF_MUL8 = 17'h00010;

  // control register layout
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [3:0] word_len_m1;
    logic [2:0] rsv_lo;
    logic flag1_val;
    logic flag0_val;
    logic flag1_oe;
    logic flag0_oe;
    logic fsync_internal;
    logic clock_internal;
    logic rx_enable;
    logic tx_enable;
    logic shift_direction;
    logic frame_length_mix;
    logic frame_length_select;
    logic gated_clock;
    logic tx_rx_sync_select;
  } spfc_ctrl_t;

  // divider register layout
  typedef struct packed {
    logic [10:0] rsv_hi;
    logic [4:0] frame_div;
    logic [2:0] rsv_lo;
    logic prescale_fixed8;
    logic [11:0] prescale_mod;
  } spfc_div_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } spfc_apb_req_t;

  // one bit per multiplexed port pin
  typedef struct packed {
    logic sck;
    logic aux_pin_zero;
    logic aux_pin_one;
    logic aux_pin_two;
    logic txd;
  } spfc_pins_t;

endpackage

// *** spfc_port.sv ***
// synchronous serial port: framing, pin muxing, shifters and apb registers
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module spfc_port
  import spfc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb slave
  input wire spfc_apb_req_t apb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // port pins: input level, output level, active-low enable
  input wire spfc_pins_t pin_i,
  output spfc_pins_t pin_o,
  output spfc_pins_t pin_oe_n_o,
  input wire logic rx_data_i,
  // interrupts
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic irq_o
);

  typedef struct packed {
    spfc_ctrl_t ctrl;
    spfc_div_t div;
    logic [SPFC_ST_W-1:0] mask;
    logic [SPFC_ST_W-1:0] stat;
    logic [15:0] txd;
    logic tx_held;
    logic [15:0] rxd;
    logic rx_held;
    logic [31:0] prdata;
    logic pslverr;
    logic [16:0] gcnt;
    logic bclk;
    logic [9:0] gbit;
    logic irise;
    logic ifall;
    logic ifs_tx;
    logic ifs_rx;
    logic sck_p;
    logic aux0_p;
    logic t_act;
    logic t_arm;
    logic t_fsp;
    logic [4:0] t_cnt;
    logic [15:0] t_word;
    logic t_out;
    logic t_oe_n;
    logic r_act;
    logic r_arm;
    logic r_fsp;
    logic [4:0] r_cnt;
    logic [15:0] r_word;
    spfc_pins_t pins;
    spfc_pins_t pins_oe_n;
  } spfc_state_t;

  spfc_state_t st_r;
  spfc_state_t st_nxt;

  // bit position of the cnt-th bit on the wire within a word
  function automatic logic [3:0] spfc_bit_idx(input logic lsb_first,
    input logic [3:0] wl_m1, input logic [4:0] cnt);
    spfc_bit_idx = lsb_first ? cnt[3:0] : wl_m1 - cnt[3:0];
  endfunction

  // decoded views used by the datapath and the checks
  logic [3:0] wl;
  logic tx_bitlen;
  logic rx_bitlen;
  logic ext_gated;
  logic t_rise;
  logic t_fall;
  logic r_rise;
  logic r_fall;
  logic t_fs;
  logic r_fs;
  logic t_lead;
  logic r_lead;
  logic t_go;
  logic r_go;
  logic [16:0] half_m1;
  logic [9:0] period_m1;
  logic [SPFC_ST_W-1:0] ev;
  logic setup;
  logic access;
  logic [15:0] rw;
  logic [15:0] tw;

  always_comb
  begin
    st_nxt = st_r;
    ev = '0;
    rw = st_r.r_word;
    tw = st_r.txd;
    wl = st_r.ctrl.word_len_m1;
    // rx follows the select bit, tx takes the opposite when mixed
    rx_bitlen = st_r.ctrl.frame_length_select;
    tx_bitlen = st_r.ctrl.frame_length_select
      ^ st_r.ctrl.frame_length_mix;
    ext_gated = st_r.ctrl.gated_clock & !st_r.ctrl.clock_internal;

    // bit clock: fixed prescale then modulus prescale
    half_m1 = 17'(({4'h0, 13'(st_r.div.prescale_mod) + 13'h0001}
      * (st_r.div.prescale_fixed8 ? SPFC_HALF_MUL8 : SPFC_HALF_MUL1))
      - 17'h00001);
    // frame length in bits: word length times words per frame
    period_m1 = 10'((10'({6'h0, wl}) + 10'h001)
      * (10'({5'h00, st_r.div.frame_div}) + 10'h001) - 10'h001);
    st_nxt.irise = 1'b0;
    st_nxt.ifall = 1'b0;
    if (st_r.gcnt >= half_m1)
    begin
      st_nxt.gcnt = '0;
      st_nxt.bclk = !st_r.bclk;
      st_nxt.irise = !st_r.bclk;
      st_nxt.ifall = st_r.bclk;
      if (!st_r.bclk)
      begin
        st_nxt.gbit = (st_r.gbit >= period_m1) ? 10'h000
          : st_r.gbit + 10'h001;
      end
    end
    else
    begin
      st_nxt.gcnt = st_r.gcnt + 17'h00001;
    end
    // internal syncs: word long over data slots, bit long in last slot
    st_nxt.ifs_tx = tx_bitlen ? (st_nxt.gbit == period_m1)
      : (st_nxt.gbit <= {6'h00, wl});
    st_nxt.ifs_rx = rx_bitlen ? (st_nxt.gbit == period_m1)
      : (st_nxt.gbit <= {6'h00, wl});

    // clock and sync sources per direction; pins are sampled as-is
    st_nxt.sck_p = pin_i.sck;
    st_nxt.aux0_p = pin_i.aux_pin_zero;
    t_rise = st_r.ctrl.clock_internal ? st_r.irise
      : (pin_i.sck & !st_r.sck_p);
    t_fall = st_r.ctrl.clock_internal ? st_r.ifall
      : (!pin_i.sck & st_r.sck_p);
    if (st_r.ctrl.tx_rx_sync_select)
    begin
      r_rise = t_rise;
      r_fall = t_fall;
    end
    else
    begin
      r_rise = st_r.ctrl.clock_internal ? st_r.irise
        : (pin_i.aux_pin_zero & !st_r.aux0_p);
      r_fall = st_r.ctrl.clock_internal ? st_r.ifall
        : (!pin_i.aux_pin_zero & st_r.aux0_p);
    end
    t_fs = st_r.ctrl.fsync_internal ? st_r.ifs_tx : pin_i.aux_pin_two;
    if (st_r.ctrl.fsync_internal)
    begin
      r_fs = st_r.ifs_rx;
    end
    else
    begin
      r_fs = st_r.ctrl.tx_rx_sync_select ? pin_i.aux_pin_two
        : pin_i.aux_pin_one;
    end
    t_lead = t_fs & !st_r.t_fsp;
    r_lead = r_fs & !st_r.r_fsp;
    // external gated clock carries its own framing; syncs unused
    t_go = ext_gated | (tx_bitlen ? st_r.t_arm : t_lead);
    r_go = ext_gated | (rx_bitlen ? st_r.r_arm : r_lead);

    // transmitter: drive on rising edge, release on falling edge
    if (t_rise)
    begin
      st_nxt.t_fsp = t_fs;
      st_nxt.t_arm = tx_bitlen & t_lead;
      if (st_r.t_act)
      begin
        if (st_r.t_cnt <= {1'b0, wl})
        begin
          st_nxt.t_out = st_r.t_word[spfc_bit_idx(
            st_r.ctrl.shift_direction, wl, st_r.t_cnt)];
          st_nxt.t_cnt = st_r.t_cnt + 5'h01;
        end
      end
      else if (t_go & st_r.ctrl.tx_enable)
      begin
        // on underrun the previous word is sent again
        tw = st_r.tx_held ? st_r.txd : st_r.t_word;
        st_nxt.t_word = tw;
        st_nxt.t_out = tw[spfc_bit_idx(st_r.ctrl.shift_direction, wl,
          5'h00)];
        st_nxt.t_cnt = 5'h01;
        st_nxt.t_act = 1'b1;
        st_nxt.t_oe_n = 1'b0;
        st_nxt.tx_held = 1'b0;
        ev[SPFC_ST_TXE] = 1'b1;
        ev[SPFC_ST_TXU] = !st_r.tx_held;
      end
    end
    else if (t_fall & st_r.t_act & (st_r.t_cnt == 5'({1'b0, wl}) + 5'h01))
    begin
      // floated in every gap between frames
      st_nxt.t_act = 1'b0;
      st_nxt.t_oe_n = 1'b1;
    end

    // receiver: frame sync on rising edge, sample on falling edge
    if (r_rise)
    begin
      st_nxt.r_fsp = r_fs;
      // a bit sync may overlap the last bit of the running frame
      st_nxt.r_arm = rx_bitlen & r_lead & (!st_r.r_act
        | (st_r.r_cnt == {1'b0, wl}));
      if (!st_r.r_act)
      begin
        if (r_go & st_r.ctrl.rx_enable)
        begin
          st_nxt.r_act = 1'b1;
          st_nxt.r_cnt = 5'h00;
          st_nxt.r_word = 16'h0000;
        end
      end
      else if (r_lead & !ext_gated
        & !(rx_bitlen & (st_r.r_cnt == {1'b0, wl})))
      begin
        // early edge is not recognised; the partner broke framing
        ev[SPFC_ST_DROP] = 1'b1;
      end
    end
    if (r_fall & st_r.r_act)
    begin
      rw[spfc_bit_idx(st_r.ctrl.shift_direction, wl, st_r.r_cnt)]
        = rx_data_i;
      st_nxt.r_word = rw;
      st_nxt.r_cnt = st_r.r_cnt + 5'h01;
      if (st_r.r_cnt == {1'b0, wl})
      begin
        st_nxt.r_act = 1'b0;
        st_nxt.rxd = rw;
        st_nxt.rx_held = 1'b1;
        ev[SPFC_ST_RXF] = 1'b1;
        ev[SPFC_ST_RXO] = st_r.rx_held;
      end
    end

    // apb: read data is captured in the setup cycle, zero wait states
    setup = apb_i.psel & !apb_i.penable;
    access = apb_i.psel & apb_i.penable;
    if (setup)
    begin
      st_nxt.pslverr = 1'b0;
      case (apb_i.paddr)
        SPFC_OFF_CTRL: st_nxt.prdata = st_r.ctrl;
        SPFC_OFF_DIV: st_nxt.prdata = st_r.div;
        SPFC_OFF_TXD: st_nxt.prdata = {16'h0000, st_r.txd};
        SPFC_OFF_RXD: st_nxt.prdata = {16'h0000, st_r.rxd};
        SPFC_OFF_STAT: st_nxt.prdata = {16'h0000, 2'h0, pin_i.aux_pin_one,
          pin_i.aux_pin_zero, 2'h0, st_r.r_act, st_r.t_act,
          3'h0, st_r.stat};
        SPFC_OFF_MASK: st_nxt.prdata = {27'h0000000, st_r.mask};
        default:
        begin
          st_nxt.prdata = 32'h0000_0000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (access & apb_i.pwrite)
    begin
      case (apb_i.paddr)
        SPFC_OFF_CTRL: st_nxt.ctrl = apb_i.pwdata;
        SPFC_OFF_DIV: st_nxt.div = apb_i.pwdata;
        SPFC_OFF_TXD:
        begin
          st_nxt.txd = apb_i.pwdata[15:0];
          st_nxt.tx_held = 1'b1;
        end
        SPFC_OFF_MASK: st_nxt.mask = apb_i.pwdata[SPFC_ST_W-1:0];
        default: st_nxt.pslverr = st_r.pslverr;
      endcase
    end
    if (access & !apb_i.pwrite & (apb_i.paddr == SPFC_OFF_RXD)
      & !ev[SPFC_ST_RXF])
    begin
      st_nxt.rx_held = 1'b0;
    end
    // read clears status, a new event in the same cycle still lands
    st_nxt.stat = ((access & !apb_i.pwrite
      & (apb_i.paddr == SPFC_OFF_STAT)) ? '0 : st_r.stat) | ev;

    // pin outputs registered to keep the clock pins glitch free
    st_nxt.pins.sck = st_nxt.bclk & (!st_r.ctrl.gated_clock
      | (st_nxt.gbit <= {6'h00, wl}));
    st_nxt.pins_oe_n.sck = !st_r.ctrl.clock_internal;
    st_nxt.pins.txd = st_nxt.t_out;
    st_nxt.pins_oe_n.txd = st_nxt.t_oe_n;
    st_nxt.pins.aux_pin_two = st_nxt.ifs_tx;
    st_nxt.pins_oe_n.aux_pin_two = !st_r.ctrl.fsync_internal;
    if (st_r.ctrl.tx_rx_sync_select)
    begin
      // shared timing: pins zero and one are plain flags
      st_nxt.pins.aux_pin_zero = st_r.ctrl.flag0_val;
      st_nxt.pins_oe_n.aux_pin_zero = !st_r.ctrl.flag0_oe;
      st_nxt.pins.aux_pin_one = st_r.ctrl.flag1_val;
      st_nxt.pins_oe_n.aux_pin_one = !st_r.ctrl.flag1_oe;
    end
    else
    begin
      st_nxt.pins.aux_pin_zero = st_nxt.pins.sck;
      st_nxt.pins_oe_n.aux_pin_zero = !st_r.ctrl.clock_internal;
      st_nxt.pins.aux_pin_one = st_nxt.ifs_rx;
      st_nxt.pins_oe_n.aux_pin_one = !st_r.ctrl.fsync_internal;
    end
  end

  // single state register
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r <= '0;
      st_r.ctrl <= SPFC_CTRL_RST;
      st_r.div <= SPFC_DIV_RST;
      st_r.mask <= SPFC_MASK_RST;
      st_r.t_oe_n <= 1'b1;
      st_r.pins_oe_n <= 5'h1f;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // bus answers and interrupt requests
  assign pready_o = 1'b1;
  assign prdata_o = st_r.prdata;
  assign pslverr_o = st_r.pslverr;
  assign pin_o = st_r.pins;
  assign pin_oe_n_o = st_r.pins_oe_n;
  assign rx_irq_o = |(st_r.stat & st_r.mask & 5'h1c);
  assign tx_irq_o = |(st_r.stat & st_r.mask & 5'h03);
  assign irq_o = rx_irq_o | tx_irq_o;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence seq_tx_start;
    t_rise && !st_r.t_act && t_go && st_r.ctrl.tx_enable;
  endsequence

  sequence seq_rx_last;
    r_fall && st_r.r_act && (st_r.r_cnt == {1'b0, wl});
  endsequence

  AST_TX_HIZ_GAP: assert property (!st_r.t_act |-> st_r.t_oe_n)
    else $error("tx data driven outside a frame");
  AST_MSB_FIRST: assert property ((seq_tx_start
    and !st_r.ctrl.shift_direction) |=> st_r.t_out == st_r.t_word[wl])
    else $error("first tx bit is not the msb");
  AST_LSB_FIRST: assert property ((seq_tx_start
    and st_r.ctrl.shift_direction) |=> st_r.t_out == st_r.t_word[0])
    else $error("first tx bit is not the lsb");
  AST_OE_ON_RISE: assert property ($fell(st_r.t_oe_n)
    |-> $past(t_rise))
    else $error("tx output enabled off a rising edge");
  AST_OE_OFF_FALL: assert property ($rose(st_r.t_oe_n)
    |-> $past(t_fall))
    else $error("tx output released off a falling edge");
  AST_GATED_NO_FS: assert property (ext_gated && t_rise
    && !st_r.t_act && st_r.ctrl.tx_enable |=> st_r.t_act)
    else $error("external gated clock did not start a word");
  AST_EARLY_EDGE: assert property (r_rise && st_r.r_act && r_lead
    && !ext_gated && !(rx_bitlen && (st_r.r_cnt == {1'b0, wl}))
    |=> st_r.stat[SPFC_ST_DROP] && st_r.r_act)
    else $error("early frame sync was not ignored");
  AST_RX_IRQ: assert property (seq_rx_last
    ##0 st_r.mask[SPFC_ST_RXF] |=> rx_irq_o && st_r.rxd == $past(rw))
    else $error("received word or rx interrupt missing");
  AST_SYNC_CLK: assert property (st_r.ctrl.tx_rx_sync_select
    |-> (r_rise == t_rise) && (r_fall == t_fall))
    else $error("shared clock differs between directions");
  AST_ASYNC_CLK: assert property (!st_r.ctrl.tx_rx_sync_select
    && !st_r.ctrl.clock_internal && pin_i.aux_pin_zero
    && !st_r.aux0_p |-> r_rise)
    else $error("rx clock pin edge not used by receiver");
  AST_BIT_SYNC: assert property (r_rise && st_r.r_arm && !st_r.r_act
    && st_r.ctrl.rx_enable && rx_bitlen
    |=> st_r.r_act && st_r.r_cnt == 5'h00)
    else $error("bit sync did not start the next bit");
  // the sync flop was loaded under last cycle's format and word length
  AST_WORD_SYNC: assert property (st_r.irise && !$past(tx_bitlen)
    |-> st_r.ifs_tx == (st_r.gbit <= {6'h00, $past(wl)}))
    else $error("word sync does not cover the data slots");

endmodule

// *** test_serial_port_framing_config.sv ***
// self-checking bench for the serial port framing block
`timescale 1ns/1ps
module test_serial_port_framing_config;
  import spfc_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  spfc_apb_req_t req = '0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  spfc_pins_t pin_in;
  spfc_pins_t pin_out;
  spfc_pins_t pin_oe_n;
  spfc_pins_t ext;
  logic p_sck;
  logic p_fs;
  logic p_rxd;
  logic [7:0] tx_seen;
  int oe_miss;
  logic rx_irq;
  logic tx_irq;
  logic irq;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 clock_i = ~clock_i;

  // codec clock and sync feed both tx and rx pins, so async matches sync
  assign ext = {p_sck, p_sck, p_fs, p_fs, 1'b0};
  assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);

  spfc_port spfc_port_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .apb_i(req), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_n_o(pin_oe_n), .rx_data_i(p_rxd),
    .rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .irq_o(irq));

  spfc_codec_model #(.HALF(6)) spfc_codec_model_inst (
    .clock_i(clock_i), .txd_i(pin_out.txd), .txd_oe_n_i(pin_oe_n.txd),
    .sck_o(p_sck), .fs_o(p_fs), .rxd_o(p_rxd), .tx_seen_o(tx_seen),
    .oe_miss_o(oe_miss));

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  // apb transfer: request held until pready is seen high
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clock_i);
    req.penable <= 1'b1;
    // no wait count assumed; only the bench timeout ends a hang
    do
    begin
      @(posedge clock_i);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly 1400 cycles the run needs
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [31:0] rnd;
    spfc_ctrl_t c;
    logic [7:0] rw;
    logic [7:0] tw;
    logic [4:0] m;
    bit fsl;
    bit shd;
    bit g;
    bit early;
    int k;
    int n_rfs;
    int n_tfs;
    logic prev;
    bit [9:0] fsl_tab = 10'b0000101010;
    bit [9:0] shd_tab = 10'b0000001100;
    bit [9:0] syn_tab = 10'b0000110011;
    bit [9:0] g_tab = 10'b0000010000;
    bit [9:0] early_tab = 10'b0000100000;
    void'($urandom(35));
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    apb(0, SPFC_OFF_CTRL, '0, q, e);
    chk("ctrl reset", SPFC_CTRL_RST, q);
    apb(0, SPFC_OFF_DIV, '0, q, e);
    chk("div reset", SPFC_DIV_RST, q);
    apb(0, SPFC_OFF_MASK, '0, q, e);
    chk("mask reset", {27'h0, SPFC_MASK_RST}, q);
    apb(1, 8'h18, 32'hffff_ffff, q, e);
    apb(0, 8'h18, '0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // table of corner modes first, then random formats
    for (k = 0; k < 10; k++)
    begin
      rnd = $urandom;
      rw = 8'($urandom);
      tw = 8'($urandom);
      fsl = (k < 6) ? fsl_tab[k] : rnd[0];
      shd = (k < 6) ? shd_tab[k] : rnd[1];
      g = g_tab[k];
      early = early_tab[k];
      m = (k == 1) ? 5'h1c : (k == 2) ? 5'h03 : (k >= 6) ? rnd[8:4] : 5'h1f;
      c = '0;
      c.tx_rx_sync_select = (k < 6) ? syn_tab[k] : rnd[2];
      c.gated_clock = g;
      c.frame_length_select = fsl;
      c.shift_direction = shd;
      c.tx_enable = 1'b1;
      c.rx_enable = 1'b1;
      c.word_len_m1 = 4'h7;
      apb(1, SPFC_OFF_MASK, {27'h0, m}, q, e);
      apb(1, SPFC_OFF_CTRL, c, q, e);
      apb(1, SPFC_OFF_TXD, {24'h0, tw}, q, e);
      spfc_codec_model_inst.frame(rw, g ? 2 : (fsl ? 1 : 0), shd, early);
      repeat (6) @(posedge clock_i);
      chk("txd released", 32'h1, {31'h0, pin_oe_n.txd});
      chk("txd enabled", 32'h0, oe_miss);
      chk("rx irq", {31'h0, m[2] | (early & m[4])}, {31'h0, rx_irq});
      if (!early)
      begin
        chk("tx irq", {31'h0, m[0]}, {31'h0, tx_irq});
        chk("tx word", {24'h0, tw}, {24'h0, tx_seen});
      end
      apb(0, SPFC_OFF_STAT, '0, q, e);
      chk("status rx", {29'h0, early, 2'b01}, {29'h0, q[4:2]});
      if (!early) chk("status tx", 32'h1, {30'h0, q[1:0]});
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(0, SPFC_OFF_RXD, '0, q, e);
      chk("rx word", {24'h0, rw}, q);
    end
    // internal timing, separate sections: clock and both syncs driven;
    // mixed lengths give tx a word sync and rx a bit sync
    c = '0;
    c.clock_internal = 1'b1;
    c.fsync_internal = 1'b1;
    c.frame_length_select = 1'b1;
    c.frame_length_mix = 1'b1;
    c.word_len_m1 = 4'h7;
    apb(1, SPFC_OFF_CTRL, c, q, e);
    repeat (2) @(posedge clock_i);
    chk("internal pins oe_n", 32'h1, {27'h0, pin_oe_n});
    k = 0;
    n_rfs = 0;
    n_tfs = 0;
    prev = pin_out.sck;
    repeat (40)
    begin
      @(posedge clock_i);
      if (pin_out.sck === 1'b1 && prev === 1'b0) k++;
      prev = pin_out.sck;
      n_rfs += pin_out.aux_pin_one;
      n_tfs += pin_out.aux_pin_two;
    end
    chk("bit clock rises", 32'(40 / (2 * SPFC_HALF_MUL1)), k);
    chk("tx sync pin", 32'h28, n_tfs);
    chk("rx sync pin", 32'h1, 32'(n_rfs >= 4 && n_rfs <= 8));
    // shared timing: pin zero turns into a driven flag, pin one an input
    c.tx_rx_sync_select = 1'b1;
    c.flag0_oe = 1'b1;
    c.flag0_val = 1'b1;
    apb(1, SPFC_OFF_CTRL, c, q, e);
    repeat (2) @(posedge clock_i);
    q = {29'h0, pin_out.aux_pin_zero, pin_oe_n.aux_pin_zero,
      pin_oe_n.aux_pin_one};
    chk("flag pins", 32'h5, q);
    wrap_up();
  end
endmodule
